// file: rtl/fsr_defs.svh
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// register offsets
`define FSR_PWR_CTRL_ADDR 8'h04
`define FSR_LEFT_INFL_ADDR 8'h10
`define FSR_RIGHT_INFL_ADDR 8'h13
`define FSR_THERM_GAIN_ADDR 8'h16
`define FSR_RECOVERY_ADDR 8'h17
`define FSR_SUPPLY_STAT_ADDR 8'h18
`define FSR_CHAN_STAT_ADDR 8'h19
`define FSR_VBAT_READ_ADDR 8'h1a
`define FSR_TEMP_READ_ADDR 8'h1b

// reset values
`define FSR_PWR_CTRL_RST 8'h20
`define FSR_INFL_RST 8'h00
`define FSR_THERM_GAIN_RST 8'h00
`define FSR_RECOVERY_RST 8'h00
`define FSR_READ_RST 8'h00

// field positions
`define FSR_SENSOR_SHDN_BIT 5
`define FSR_OVERCURRENT_AUTO_RECOVERY_SELECT_BIT 0
`define FSR_ARCV_OT_BIT 1
`define FSR_UNDERVOLTAGE_AUTO_RECOVERY_SELECT_BIT 2
`define FSR_MANUAL_RCV_BIT 3
`define FSR_ATTEMPT_MSB 7
`define FSR_ATTEMPT_LSB 6
`define FSR_RECOVERY_KEEP 8'hf7
`define FSR_GAIN_L_MSB 1
`define FSR_GAIN_L_LSB 0
`define FSR_GAIN_R_MSB 5
`define FSR_GAIN_R_LSB 4
`define FSR_THERM_GAIN_KEEP 8'h33

// temperature code offset and thresholds, in degrees Celsius
`define FSR_TEMP_OFFSET 60
`define FSR_OTF_DEG 145
`define FSR_OTW_DEG 117

// retry spacing for automatic recovery
`define FSR_CLK_MHZ 40
`define FSR_RETRY_NS 10000
`define FSR_RETRY_CYC ((`FSR_RETRY_NS * `FSR_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/fsr_pkg.sv
package fsr_pkg;

	// live fault and event levels from the analog side
	typedef struct packed {
		logic pvdd_uv;
		logic vreg_uv;
		logic oc_l;
		logic oc_r;
		logic lim_l;
		logic lim_r;
		logic clip_l;
		logic clip_r;
	} fsr_fault_in_t;

	// register access from the control port byte engine
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fsr_reg_req_t;

	// recovery sequencer
	typedef enum logic [1:0] {
		FSR_RUN,
		FSR_DOWN,
		FSR_HOLD
	} fsr_state_t;

endpackage

// file: rtl/fsr_top.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"
// Summary of operation
// - temperature converter runs only when software enables
// - enabled sensor result readable in temperature register
// - temperature code is degrees Celsius plus sixty
// - supply undervoltage sets first status bit seven
// - regulator undervoltage sets first status bit six
// - limiter engaged: second status bits three, seven
// - clipping: second status bits two, six
// - overcurrent: second status bits one, five
// - above 145 degrees sets overtemperature fault bit
// - above 117 degrees sets early warning bit
// - supply above inflection sets battery warning bits
// - warning applies programmed per-channel gain reduction
// - recovery register selects automatic or manual per class
// - automatic mode retries until the fault clears or the attempt limit is hit
// - manual mode stays down until controller retries
// - writable manual recovery control starts an attempt
// - automatic attempt count is programmable
// - both status registers readable over control port
// - supply converter result held in readout register
// - supply code is 3.8 V plus 12.4 V times code/255
// - inflection levels are codes on supply scale

module fsr_top (
	input wire logic CLK_IN, // 40 MHz control clock
	input wire logic RST_N_IN, // synchronous reset, active low
	input wire fsr_pkg::fsr_reg_req_t REG_REQ_IN, // register access
	output logic [7:0] REG_RDATA_OUT, // read data, registered
	output logic REG_RVALID_OUT, // read data valid pulse
	input wire fsr_pkg::fsr_fault_in_t FAULTS_IN, // analog fault levels
	input wire logic [7:0] TEMP_CODE_IN, // temperature converter code
	input wire logic TEMP_VALID_IN, // new temperature code pulse
	input wire logic [7:0] VBAT_CODE_IN, // supply converter code
	input wire logic VBAT_VALID_IN, // new supply code pulse
	output logic TEMP_ADC_EN_OUT, // runs temperature converter
	output logic AMP_SHUTDOWN_OUT, // holds power stage off
	output logic [1:0] LEFT_GAIN_CUT_OUT, // left thermal gain cut
	output logic [1:0] RIGHT_GAIN_CUT_OUT // right thermal gain cut
);

	////////////////////////////////////////////////////////////////////////
	// constants and helpers

	localparam logic [7:0] OTF_CODE = 8'(`FSR_OTF_DEG + `FSR_TEMP_OFFSET);
	localparam logic [7:0] OTW_CODE = 8'(`FSR_OTW_DEG + `FSR_TEMP_OFFSET);
	localparam int RETRY_CYC = (`FSR_RETRY_CYC < 1) ? 1 : `FSR_RETRY_CYC;
	localparam logic [9:0] RETRY_LAST = 10'(RETRY_CYC - 1);

	// gain cut applied while the warning stands
	function automatic logic [1:0] gain_cut(input logic warn,
			input logic [1:0] sel);
		gain_cut = warn ? sel : 2'h0;
	endfunction

	// unsigned strict compare of a converter code against a level
	function automatic logic code_above(input logic [7:0] code,
			input logic [7:0] level);
		code_above = (code > level);
	endfunction

	// register offset match, shared by the write and read decode
	function automatic logic reg_hit(input logic [7:0] addr,
			input logic [7:0] offset);
		reg_hit = (addr == offset);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and state

	logic [7:0] pwr_ctrl_q;
	logic [7:0] left_battery_inflection_level_q;
	logic [7:0] right_battery_inflection_level_q;
	logic [7:0] therm_gain_q;
	logic [7:0] recovery_q;
	logic [7:0] temp_code_q;
	logic [7:0] vbat_code_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	fsr_pkg::fsr_state_t state_q;
	logic [9:0] timer_q;
	logic [1:0] attempts_q;

	logic thermal_sensor_shutdown;
	logic overtemperature_fault_flag;
	logic overtemperature_warning_flag;
	logic left_battery_threshold_flag;
	logic right_battery_threshold_flag;
	logic uv_fault;
	logic oc_fault;
	logic any_fault;
	logic manual_class_fault;
	logic manual_strobe;
	logic [1:0] attempt_limit;
	logic limit_hit;
	logic [7:0] supply_status;
	logic [7:0] channel_status;
	logic [7:0] req_addr;
	logic sel_pwr_ctrl;
	logic sel_left_infl;
	logic sel_right_infl;
	logic sel_therm_gain;
	logic sel_recovery;
	logic sel_supply_stat;
	logic sel_chan_stat;
	logic sel_vbat_read;
	logic sel_temp_read;

	////////////////////////////////////////////////////////////////////////
	// decoded controls

	assign thermal_sensor_shutdown = pwr_ctrl_q[`FSR_SENSOR_SHDN_BIT];
	assign attempt_limit = recovery_q[`FSR_ATTEMPT_MSB:`FSR_ATTEMPT_LSB];
	assign manual_strobe = REG_REQ_IN.wr &&
		sel_recovery &&
		REG_REQ_IN.wdata[`FSR_MANUAL_RCV_BIT];

	// one select per offset, shared by the write and read decode
	assign req_addr = REG_REQ_IN.addr;
	assign sel_pwr_ctrl = reg_hit(req_addr, `FSR_PWR_CTRL_ADDR);
	assign sel_left_infl = reg_hit(req_addr, `FSR_LEFT_INFL_ADDR);
	assign sel_right_infl = reg_hit(req_addr, `FSR_RIGHT_INFL_ADDR);
	assign sel_therm_gain = reg_hit(req_addr, `FSR_THERM_GAIN_ADDR);
	assign sel_recovery = reg_hit(req_addr, `FSR_RECOVERY_ADDR);
	assign sel_supply_stat = reg_hit(req_addr, `FSR_SUPPLY_STAT_ADDR);
	assign sel_chan_stat = reg_hit(req_addr, `FSR_CHAN_STAT_ADDR);
	assign sel_vbat_read = reg_hit(req_addr, `FSR_VBAT_READ_ADDR);
	assign sel_temp_read = reg_hit(req_addr, `FSR_TEMP_READ_ADDR);

	// converter enable follows the shutdown control
	assign TEMP_ADC_EN_OUT = ~thermal_sensor_shutdown;

	////////////////////////////////////////////////////////////////////////
	// live fault conditions

	// thermal flags compare the offset code against offset limits
	assign overtemperature_fault_flag =
		code_above(temp_code_q, OTF_CODE);
	assign overtemperature_warning_flag =
		code_above(temp_code_q, OTW_CODE);

	// battery warning uses the same code scale as the readout
	assign left_battery_threshold_flag = code_above(vbat_code_q,
		left_battery_inflection_level_q);
	assign right_battery_threshold_flag = code_above(vbat_code_q,
		right_battery_inflection_level_q);

	// protection classes that stop the power stage
	assign uv_fault = FAULTS_IN.pvdd_uv | FAULTS_IN.vreg_uv;
	assign oc_fault = FAULTS_IN.oc_l | FAULTS_IN.oc_r;
	assign any_fault = uv_fault | oc_fault | overtemperature_fault_flag;

	// a faulting class set to manual forces a held shutdown
	assign manual_class_fault =
		(uv_fault & recovery_q[`FSR_UNDERVOLTAGE_AUTO_RECOVERY_SELECT_BIT]) |
		(oc_fault & recovery_q[`FSR_OVERCURRENT_AUTO_RECOVERY_SELECT_BIT]) |
		(overtemperature_fault_flag &
			recovery_q[`FSR_ARCV_OT_BIT]);

	// zero attempts selects unlimited retries
	assign limit_hit = (attempt_limit != 2'h0) &&
		(attempts_q >= attempt_limit);

	////////////////////////////////////////////////////////////////////////
	// status bytes, always the present condition

	always_comb begin
		supply_status = 8'h00;
		supply_status[7] = FAULTS_IN.pvdd_uv;
		supply_status[6] = FAULTS_IN.vreg_uv;
		supply_status[1] = overtemperature_fault_flag;
		supply_status[0] = overtemperature_warning_flag;
	end

	always_comb begin
		channel_status = 8'h00;
		channel_status[7] = FAULTS_IN.lim_r;
		channel_status[6] = FAULTS_IN.clip_r;
		channel_status[5] = FAULTS_IN.oc_r;
		channel_status[4] = right_battery_threshold_flag;
		channel_status[3] = FAULTS_IN.lim_l;
		channel_status[2] = FAULTS_IN.clip_l;
		channel_status[1] = FAULTS_IN.oc_l;
		channel_status[0] = left_battery_threshold_flag;
	end

	////////////////////////////////////////////////////////////////////////
	// writable registers; status and readout offsets ignore writes

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pwr_ctrl_q <= `FSR_PWR_CTRL_RST;
			left_battery_inflection_level_q <= `FSR_INFL_RST;
			right_battery_inflection_level_q <= `FSR_INFL_RST;
			therm_gain_q <= `FSR_THERM_GAIN_RST;
			recovery_q <= `FSR_RECOVERY_RST;
		end else if (REG_REQ_IN.wr) begin
			if (sel_pwr_ctrl) begin
				pwr_ctrl_q <= REG_REQ_IN.wdata;
			end else if (sel_left_infl) begin
				left_battery_inflection_level_q <= REG_REQ_IN.wdata;
			end else if (sel_right_infl) begin
				right_battery_inflection_level_q <= REG_REQ_IN.wdata;
			end else if (sel_therm_gain) begin
				therm_gain_q <= REG_REQ_IN.wdata &
					`FSR_THERM_GAIN_KEEP;
			end else if (sel_recovery) begin
				// manual recovery bit is a strobe, never stored
				recovery_q <= REG_REQ_IN.wdata &
					`FSR_RECOVERY_KEEP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// converter readouts

	// temperature result captured only while the sensor runs
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			temp_code_q <= `FSR_READ_RST;
		end else if (TEMP_VALID_IN && !thermal_sensor_shutdown) begin
			temp_code_q <= TEMP_CODE_IN;
		end
	end

	// supply result, code n is 3.8 V + 12.4 V * n / 255
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			vbat_code_q <= `FSR_READ_RST;
		end else if (VBAT_VALID_IN) begin
			vbat_code_q <= VBAT_CODE_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read path, one cycle after the strobe

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= REG_REQ_IN.rd;
			if (REG_REQ_IN.rd) begin
				if (sel_pwr_ctrl) begin
					rdata_q <= pwr_ctrl_q;
				end else if (sel_left_infl) begin
					rdata_q <= left_battery_inflection_level_q;
				end else if (sel_right_infl) begin
					rdata_q <= right_battery_inflection_level_q;
				end else if (sel_therm_gain) begin
					rdata_q <= therm_gain_q;
				end else if (sel_recovery) begin
					rdata_q <= recovery_q;
				end else if (sel_supply_stat) begin
					rdata_q <= supply_status;
				end else if (sel_chan_stat) begin
					rdata_q <= channel_status;
				end else if (sel_vbat_read) begin
					rdata_q <= vbat_code_q;
				end else if (sel_temp_read) begin
					rdata_q <= temp_code_q;
				end else begin
					rdata_q <= 8'h00;
				end
			end
		end
	end

	assign REG_RDATA_OUT = rdata_q;
	assign REG_RVALID_OUT = rvalid_q;

	////////////////////////////////////////////////////////////////////////
	// recovery sequencer

	// RUN: stage on; DOWN: auto retry after the spacing; HOLD: manual
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state_q <= fsr_pkg::FSR_RUN;
			timer_q <= 10'h000;
			attempts_q <= 2'h0;
		end else begin
			case (state_q)
				fsr_pkg::FSR_RUN: begin
					if (any_fault && manual_class_fault) begin
						state_q <= fsr_pkg::FSR_HOLD;
						timer_q <= 10'h000;
					end else if (any_fault) begin
						state_q <= fsr_pkg::FSR_DOWN;
						timer_q <= 10'h000;
					end else if (timer_q == RETRY_LAST) begin
						// a full clean spacing ends the retry series
						attempts_q <= 2'h0;
					end else begin
						timer_q <= timer_q + 10'h001;
					end
				end
				fsr_pkg::FSR_DOWN: begin
					if (manual_class_fault) begin
						state_q <= fsr_pkg::FSR_HOLD;
					end else if (manual_strobe) begin
						state_q <= fsr_pkg::FSR_RUN;
						timer_q <= 10'h000;
						attempts_q <= 2'h0;
					end else if (limit_hit) begin
						state_q <= fsr_pkg::FSR_HOLD;
					end else if (timer_q == RETRY_LAST) begin
						// try again; a lasting fault re-enters DOWN
						state_q <= fsr_pkg::FSR_RUN;
						timer_q <= 10'h000;
						if (attempts_q != 2'h3) begin
							attempts_q <= attempts_q + 2'h1;
						end
					end else begin
						timer_q <= timer_q + 10'h001;
					end
				end
				fsr_pkg::FSR_HOLD: begin
					if (manual_strobe) begin
						state_q <= fsr_pkg::FSR_RUN;
						timer_q <= 10'h000;
						attempts_q <= 2'h0;
					end
				end
				default: begin
					state_q <= fsr_pkg::FSR_RUN;
				end
			endcase
		end
	end

	// stage is off whenever the sequencer is not running
	assign AMP_SHUTDOWN_OUT = (state_q != fsr_pkg::FSR_RUN);

	////////////////////////////////////////////////////////////////////////
	// thermal warning gain reduction

	assign LEFT_GAIN_CUT_OUT = gain_cut(overtemperature_warning_flag,
		therm_gain_q[`FSR_GAIN_L_MSB:`FSR_GAIN_L_LSB]);
	assign RIGHT_GAIN_CUT_OUT = gain_cut(overtemperature_warning_flag,
		therm_gain_q[`FSR_GAIN_R_MSB:`FSR_GAIN_R_LSB]);

endmodule

// file: sim/fsr_top_assertions.sv
`timescale 1ns/1ps
module fsr_top_assertions (
	input wire logic CLK_IN, // clock
	input wire logic RST_N_IN, // reset
	input wire fsr_pkg::fsr_reg_req_t REG_REQ_IN, // requests
	input wire logic [7:0] REG_RDATA_OUT, // read data
	input wire logic REG_RVALID_OUT, // read valid
	input wire fsr_pkg::fsr_fault_in_t FAULTS_IN, // faults
	input wire logic [7:0] TEMP_CODE_IN, // temp code
	input wire logic TEMP_VALID_IN, // temp valid
	input wire logic [7:0] VBAT_CODE_IN, // supply code
	input wire logic VBAT_VALID_IN, // supply valid
	input wire logic TEMP_ADC_EN_OUT, // sensor run
	input wire logic AMP_SHUTDOWN_OUT, // stage off
	input wire logic [1:0] LEFT_GAIN_CUT_OUT, // left cut
	input wire logic [1:0] RIGHT_GAIN_CUT_OUT // right cut
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	fsr_pkg::fsr_fault_in_t f_q;
	wire logic rd_18 = REG_REQ_IN.rd && REG_REQ_IN.addr == 8'h18;
	wire logic rd_19 = REG_REQ_IN.rd && REG_REQ_IN.addr == 8'h19;

	// fault levels seen at the read edge
	always_ff @(posedge CLK_IN) begin
		f_q <= FAULTS_IN;
	end

	a_read_answer: assert property (REG_REQ_IN.rd |=> REG_RVALID_OUT)
		else $error("read not answered");
	a_valid_cause: assert property (REG_RVALID_OUT |-> $past(REG_REQ_IN.rd))
		else $error("valid without read");
	a_sensor_enable: assert property (
		REG_REQ_IN.wr && REG_REQ_IN.addr == 8'h04 |=>
		TEMP_ADC_EN_OUT == !$past(REG_REQ_IN.wdata[5]))
		else $error("sensor enable wrong");
	a_supply_flags: assert property (rd_18 |=>
		REG_RDATA_OUT[7:2] == {f_q.pvdd_uv, f_q.vreg_uv, 4'h0})
		else $error("supply status wrong");
	a_chan_flags: assert property (rd_19 |=>
		{REG_RDATA_OUT[7:5], REG_RDATA_OUT[3:1]} == {f_q.lim_r,
		f_q.clip_r, f_q.oc_r, f_q.lim_l, f_q.clip_l, f_q.oc_l})
		else $error("channel status wrong");
	a_unmapped_zero: assert property (
		REG_REQ_IN.rd && REG_REQ_IN.addr == 8'h00 |=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_fault_shutdown: assert property (
		FAULTS_IN.oc_l && !AMP_SHUTDOWN_OUT |=> AMP_SHUTDOWN_OUT)
		else $error("fault did not shut down");
	a_retry_spacing: assert property (
		$rose(AMP_SHUTDOWN_OUT) |-> AMP_SHUTDOWN_OUT [*8])
		else $error("shutdown too short");
	a_gain_cool: assert property (
		TEMP_VALID_IN && TEMP_ADC_EN_OUT && TEMP_CODE_IN <= 8'hb1 |=>
		LEFT_GAIN_CUT_OUT == 2'h0 && RIGHT_GAIN_CUT_OUT == 2'h0)
		else $error("gain cut while cool");

	c_temp_read: cover property (REG_REQ_IN.rd && REG_REQ_IN.addr == 8'h1b);
	c_shutdown: cover property ($rose(AMP_SHUTDOWN_OUT));
	c_gain_cut: cover property (LEFT_GAIN_CUT_OUT != 2'h0);
endmodule

bind fsr_top fsr_top_assertions i_fsr_top_assertions (.CLK_IN, .RST_N_IN,
	.REG_REQ_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .FAULTS_IN,
	.TEMP_CODE_IN, .TEMP_VALID_IN, .VBAT_CODE_IN, .VBAT_VALID_IN,
	.TEMP_ADC_EN_OUT, .AMP_SHUTDOWN_OUT, .LEFT_GAIN_CUT_OUT,
	.RIGHT_GAIN_CUT_OUT);

// file: sim/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
	input wire logic CLK_IN, // control clock
	input wire logic [7:0] REG_RDATA_IN, // read data
	input wire logic REG_RVALID_IN, // read valid
	output fsr_pkg::fsr_reg_req_t REG_REQ_OUT // request
);
	initial REG_REQ_OUT = '0;

	// one-cycle write, then released lines show junk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge CLK_IN);
		REG_REQ_OUT = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(negedge CLK_IN);
		REG_REQ_OUT = {~REG_REQ_OUT[17:2], 2'b00};
	endtask

	// one-cycle read, answer taken one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge CLK_IN);
		REG_REQ_OUT = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge CLK_IN);
		REG_REQ_OUT = {~REG_REQ_OUT[17:2], 2'b00};
		ok = REG_RVALID_IN;
		d = REG_RDATA_IN;
	endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_n = 1'b0, ok, tval = 1'b0, vval = 1'b0;
	logic adc_en, shdn, rvalid;
	logic [7:0] rdata, d, tcode = 8'h00, vcode = 8'h00;
	logic [1:0] gl, gr;
	fsr_pkg::fsr_reg_req_t req;
	fsr_pkg::fsr_fault_in_t flt = '0;
	int error_cnt = 0, comparisons = 0, lows, c;
	int m_pwr = 32'h20, m_il = 0, m_ir = 0, m_gain = 0, m_rcv = 0;
	int m_temp = 0, m_vbat = 0;
	logic [7:0] addrs[10] = '{8'h04, 8'h10, 8'h13, 8'h16, 8'h17, 8'h18,
		8'h19, 8'h1a, 8'h1b, 8'h00};
	logic [7:0] temps[7] = '{8'h54, 8'hb1, 8'hb2, 8'hcd, 8'hce, 8'hff, 8'h00};

	fsr_top i_fsr_top (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_REQ_IN(req),
		.REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .FAULTS_IN(flt),
		.TEMP_CODE_IN(tcode), .TEMP_VALID_IN(tval), .VBAT_CODE_IN(vcode),
		.VBAT_VALID_IN(vval), .TEMP_ADC_EN_OUT(adc_en),
		.AMP_SHUTDOWN_OUT(shdn), .LEFT_GAIN_CUT_OUT(gl),
		.RIGHT_GAIN_CUT_OUT(gr));
	fsr_host_model i_fsr_host_model (.CLK_IN(clk), .REG_RDATA_IN(rdata),
		.REG_RVALID_IN(rvalid), .REG_REQ_OUT(req));

	////////////////////////////////////////////////////////////////////////
	// expected read value from the register model
	function automatic int exp_rd(input logic [7:0] a);
		case (a)
			8'h04: return m_pwr;
			8'h10: return m_il;
			8'h13: return m_ir;
			8'h16: return m_gain & 8'h33;
			8'h17: return m_rcv & 8'hf7;
			8'h18: return {flt.pvdd_uv, flt.vreg_uv, 4'h0,
				m_temp > 145 + 60, m_temp > 117 + 60};
			8'h19: return {flt.lim_r, flt.clip_r, flt.oc_r, m_vbat > m_ir,
				flt.lim_l, flt.clip_l, flt.oc_l, m_vbat > m_il};
			8'h1a: return m_vbat;
			8'h1b: return m_temp;
			default: return 0;
		endcase
	endfunction

	task automatic check(input logic [7:0] got, input int exp);
		comparisons++;
		if (got !== 8'(exp)) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, 8'(exp));
		end
	endtask

	task automatic rdc(input logic [7:0] a);
		i_fsr_host_model.rd(a, d, ok);
		check({7'h0, ok}, 1);
		check(d, exp_rd(a));
	endtask

	task automatic wrm(input logic [7:0] a, input int v);
		v = v & 8'hff;
		i_fsr_host_model.wr(a, v[7:0]);
		case (a)
			8'h04: m_pwr = v;
			8'h10: m_il = v;
			8'h13: m_ir = v;
			8'h16: m_gain = v;
			8'h17: m_rcv = v;
			default: ;
		endcase
	endtask

	// converter results arrive as one-cycle pulses
	task automatic tpush(input int v);
		@(negedge clk);
		tcode = v[7:0];
		tval = 1'b1;
		@(negedge clk);
		tval = 1'b0;
		tcode = ~tcode;
		if (m_pwr[5] == 0) m_temp = v;
		check({6'h0, gl}, m_temp > 177 ? m_gain & 3 : 0);
		check({6'h0, gr}, m_temp > 177 ? m_gain >> 4 & 3 : 0);
	endtask

	task automatic vpush(input int v);
		@(negedge clk);
		vcode = v[7:0];
		vval = 1'b1;
		@(negedge clk);
		vval = 1'b0;
		vcode = ~vcode;
		m_vbat = v;
	endtask

	// overcurrent held for n cycles, counting running cycles
	task automatic hold_fault(input int n);
		lows = 0;
		@(negedge clk);
		flt.oc_l = 1'b1;
		repeat (n) begin
			@(negedge clk);
			if (shdn !== 1'b1) lows++;
		end
		flt.oc_l = 1'b0;
	endtask

	task automatic conclude;
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial begin
		c = $urandom(32'hcab8475b);
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		// reset values, random writes everywhere, read back
		foreach (addrs[k]) rdc(addrs[k]);
		check({6'h0, adc_en, shdn}, 0);
		foreach (addrs[k]) wrm(addrs[k], $urandom & 8'hf7);
		foreach (addrs[k]) rdc(addrs[k]);
		check({7'h0, adc_en}, !m_pwr[5]);
		// live status flags
		repeat (4) begin
			@(negedge clk);
			flt = 8'($urandom) & 8'h0f;
			rdc(8'h19);
		end
		@(negedge clk);
		flt = 8'hf0;
		rdc(8'h18);
		rdc(8'h19);
		@(negedge clk);
		flt = '0;
		// temperature sensor off, then on across thresholds
		wrm(8'h04, 8'h20);
		tpush(8'h54);
		rdc(8'h1b);
		wrm(8'h04, 8'h00);
		check({7'h0, adc_en}, 1);
		wrm(8'h16, ($urandom & 8'h33) | 8'h11);
		foreach (temps[k]) begin
			tpush(temps[k]);
			rdc(8'h1b);
			rdc(8'h18);
		end
		// supply against each inflection level, strict compare
		for (int j = 0; j < 2; j++) begin
			c = 1 + $urandom % 254;
			vpush(c);
			wrm(8'h10, c - 1 + j);
			wrm(8'h13, c - j);
			rdc(8'h19);
			rdc(8'h1a);
		end
		// automatic recovery after a short fault
		wrm(8'h17, 8'h08);
		repeat (450) @(negedge clk);
		hold_fault(1);
		check({7'h0, shdn}, 1);
		repeat (399) @(negedge clk);
		check({7'h0, shdn}, 1);
		@(negedge clk);
		check({7'h0, shdn}, 0);
		// manual recovery per class waits for the controller
		for (int k = 0; k < 3; k++) begin
			wrm(8'h17, 1 << k);
			if (k == 0) begin
				hold_fault(1);
			end else if (k == 1) begin
				tpush(8'hce);
				tpush(8'h00);
			end else begin
				@(negedge clk);
				flt.pvdd_uv = 1'b1;
				@(negedge clk);
				flt = '0;
			end
			repeat (600) @(negedge clk);
			check({7'h0, shdn}, 1);
			wrm(8'h17, 8'h08 | 1 << k);
			check({7'h0, shdn}, 0);
		end
		// retries with the fault held: unlimited, one, two
		for (int j = 0; j < 3; j++) begin
			wrm(8'h17, 8'h08 | j << 6);
			repeat (450) @(negedge clk);
			hold_fault(1500);
			check({7'h0, lows == (j == 0 ? 3 : j)}, 1);
		end
		conclude();
	end
endmodule
